/* verilog/status_byte_and_sync_cmds.v */
// Status summary byte, service request and command synchronisation logic.
// Assumes synchronous inputs, a command presenter that honours cmd_ready_o,
// and external event registers, queues and trigger model driving levels.
//
// How it works
// - Bits from sources; bit 6 from enabled conditions
// - Status query returns byte, changes nothing
// - No write path; bits follow sources
// - Byte weights one to 128, bit6=64
// - Bit0 measurement event; bit1 reads zero
// - Bit2 while error queue non-empty
// - Bit3 on questionable calibration error
// - Bit4 while output queue holds message
// - Bit5 on enabled standard event
// - Bit6 master summary and service request
// - Bit7 on enabled operation event
// - Trigger command equals group execute trigger
// - Trigger acted on only with bus source
// - Self-test checksum: 0 pass, 1 fail
// - Wait holds commands until overlapped ops finish
// - Only initiate, continuous-on, trigger are overlapped
// - Initiate pending until device returns idle
// - Wait after trigger releases once model settles
// - Sequential commands finish before next begins
// - Service request when enabled status bit set
// - Enable mask cleared at power-up
`timescale 1ns/1ps
`default_nettype none
`include "status_sync_consts.vh"

module status_byte_and_sync_cmds (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // Command port from the bus parser
  input  wire       cmd_valid_i,
  input  wire [3:0] cmd_code_i,
  input  wire [7:0] cmd_data_i,
  output wire       cmd_ready_o,
  output wire       cmd_done_o,
  // Response into the output queue
  output wire       resp_valid_o,
  output wire [7:0] resp_data_o,
  // Group execute trigger bus message
  input  wire       bus_get_i,
  // Serial poll
  input  wire       serial_poll_i,
  output wire       poll_valid_o,
  output wire [7:0] poll_byte_o,
  output wire       srq_o,
  // Summary sources
  input  wire       meas_event_i,
  input  wire       err_queue_nonempty_i,
  input  wire       ques_cal_err_i,
  input  wire       out_queue_nonempty_i,
  input  wire       std_event_enabled_i,
  input  wire       oper_event_enabled_i,
  // Trigger model
  input  wire       trig_src_bus_i,
  input  wire       model_idle_i,
  input  wire       model_moving_i,
  output wire       bus_trigger_o,
  output wire       initiate_o,
  output wire       init_cont_on_o,
  // ROM checksum engine
  output wire       rom_check_start_o,
  input  wire       rom_check_done_i,
  input  wire       rom_check_ok_i,
  // Status byte view
  output wire [7:0] status_summary_byte_o
);

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_TEST   = 3'd1;
  localparam [2:0] ST_WAIT   = 3'd2;
  localparam [2:0] ST_SETTLE = 3'd3;

  reg  [2:0] state_ff;
  reg  [2:0] nxt_state;
  reg  [7:0] sre_ff;
  reg  [7:0] nxt_sre;
  reg  [7:0] stb_ff;
  reg        srq_ff;
  reg        cmd_ready_ff;
  reg        nxt_cmd_ready;
  reg        cmd_done_ff;
  reg        nxt_cmd_done;
  reg        resp_valid_ff;
  reg        nxt_resp_valid;
  reg  [7:0] resp_data_ff;
  reg  [7:0] nxt_resp_data;
  reg        poll_valid_ff;
  reg  [7:0] poll_byte_ff;
  reg        bus_trig_ff;
  reg        nxt_bus_trig;
  reg        init_ff;
  reg        nxt_init;
  reg        init_cont_ff;
  reg        nxt_init_cont;
  reg        rom_start_ff;
  reg        nxt_rom_start;
  reg        init_pend_ff;
  reg        nxt_init_pend;
  reg        trig_pend_ff;
  reg        nxt_trig_pend;
  reg  [3:0] settle_ff;
  reg  [3:0] nxt_settle;

  // Decode of overlapped command codes, used only for the done flag of an accepted command
  function is_overlapped;
    input [3:0] code;
    begin
      is_overlapped = (code == `CMD_INIT) || (code == `CMD_INIT_CONT) ||
                      (code == `CMD_TRIGGER);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Status byte assembly
  // --------------------------------------------------------------------------
  // Every bit but bit 6 and the tied-zero bit 1 is a live image of its source, so clearing the source
  // is the only way to clear the bit; there is no write path at all.
  wire [7:0] src_bits;
  assign src_bits[`SB_MEAS_BIT]   = meas_event_i;
  assign src_bits[`SB_UNUSED_BIT] = 1'b0;
  assign src_bits[`SB_ERRQ_BIT]   = err_queue_nonempty_i;
  assign src_bits[`SB_QUES_BIT]   = ques_cal_err_i;
  assign src_bits[`SB_OUTQ_BIT]   = out_queue_nonempty_i;
  assign src_bits[`SB_STDEV_BIT]  = std_event_enabled_i;
  assign src_bits[`SB_MSS_BIT]    = 1'b0;
  assign src_bits[`SB_OPER_BIT]   = oper_event_enabled_i;

  // Summary recomputed every cycle; bit 6 of the mask is never stored
  wire master_summary = |(src_bits & sre_ff);

  wire [7:0] byte_now;
  assign byte_now = {src_bits[7], master_summary, src_bits[5:0]};

  // Trigger from either path, gated by the programmed control source
  wire trig_cmd  = cmd_valid_i && cmd_ready_ff && (cmd_code_i == `CMD_TRIGGER);
  wire trig_fire = (trig_cmd || bus_get_i) && trig_src_bus_i;

  // Overlapped work still in progress
  wire ops_busy = init_pend_ff || trig_pend_ff || (settle_ff != 4'h0);

  // --------------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------------
  // The sequencer has three live states. In idle every command is taken on
  // the edge where valid meets ready, and the immediate ones report done on
  // the following cycle together with any response byte.
  //
  // Self-test drops ready and waits for the checksum engine; the coded
  // result goes out as a response pulse, so it joins the output queue the
  // same way a query answer would.
  //
  // Wait drops ready and holds it low until no initiate is pending, no
  // trigger is still moving the model and the settle window has run out.
  // A wait after continuous initiation never releases on its own while
  // the model keeps running; the host must clear the device to recover.
  //
  // Overlapped commands report done at once: their work is tracked by the
  // pending flags, not by the command port, so later commands may overlap.
  //
  // Limitation: a trigger that arrives while a wait is already holding is
  // still forwarded, and the wait then also covers that trigger. This is
  // deliberate, since releasing mid-move would let a command run against a
  // model that has not settled yet.
  //
  // The pending flags are cleared one cycle after the request pulse at the
  // earliest, which hides the latency of the model reporting busy.
  always @* begin
    nxt_state      = state_ff;
    nxt_sre        = sre_ff;
    nxt_cmd_ready  = cmd_ready_ff;
    nxt_cmd_done   = 1'b0;
    nxt_resp_valid = 1'b0;
    nxt_resp_data  = resp_data_ff;
    nxt_bus_trig   = trig_fire;
    nxt_init       = 1'b0;
    nxt_init_cont  = 1'b0;
    nxt_rom_start  = 1'b0;
    nxt_init_pend  = init_pend_ff;
    nxt_trig_pend  = trig_pend_ff;
    nxt_settle     = settle_ff;
    // Initiate stays pending until the model is back in idle
    if (init_pend_ff && model_idle_i && !init_ff && !init_cont_ff) begin
      nxt_init_pend = 1'b0;
    end
    // Trigger done once the model stops moving, then a short settle window
    if (trig_pend_ff && !model_moving_i && !bus_trig_ff) begin
      nxt_trig_pend = 1'b0;
      nxt_settle    = `TRIG_SETTLE_CYC;
    end else if (settle_ff != 4'h0) begin
      nxt_settle = settle_ff - 4'h1;
    end
    if (trig_fire) begin
      nxt_trig_pend = 1'b1;
    end
    case (state_ff)
      ST_IDLE: begin
        if (cmd_valid_i && cmd_ready_ff) begin
          nxt_cmd_done = !is_overlapped(cmd_code_i) || 1'b1;
          case (cmd_code_i)
            `CMD_STB_QUERY: begin
              // Pure read of the live byte, nothing is cleared
              nxt_resp_valid = 1'b1;
              nxt_resp_data  = byte_now;
            end
            `CMD_SRE_WRITE: begin
              nxt_sre = cmd_data_i & `SRE_WRITE_MASK;
            end
            `CMD_SRE_QUERY: begin
              nxt_resp_valid = 1'b1;
              nxt_resp_data  = sre_ff;
            end
            `CMD_SELFTEST: begin
              // Sequential: no further command until checksum is in
              nxt_rom_start = 1'b1;
              nxt_cmd_ready = 1'b0;
              nxt_cmd_done  = 1'b0;
              nxt_state     = ST_TEST;
            end
            `CMD_WAIT: begin
              nxt_cmd_ready = 1'b0;
              nxt_cmd_done  = 1'b0;
              nxt_state     = ST_WAIT;
            end
            `CMD_INIT: begin
              nxt_init      = 1'b1;
              nxt_init_pend = 1'b1;
            end
            `CMD_INIT_CONT: begin
              nxt_init_cont = 1'b1;
              nxt_init_pend = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      ST_TEST: begin
        if (rom_check_done_i) begin
          nxt_resp_valid = 1'b1;
          nxt_resp_data  = rom_check_ok_i ? `TST_PASS : `TST_FAIL;
          nxt_cmd_done   = 1'b1;
          nxt_cmd_ready  = 1'b1;
          nxt_state      = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // Released only when every overlapped operation has finished
        if (!ops_busy && !trig_fire && !init_ff && !init_cont_ff) begin
          nxt_cmd_done  = 1'b1;
          nxt_cmd_ready = 1'b1;
          nxt_state     = ST_IDLE;
        end
      end
      default: begin
        nxt_cmd_ready = 1'b1;
        nxt_state     = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff      <= ST_IDLE;
      sre_ff        <= `SRE_RESET;
      stb_ff        <= `STB_RESET;
      srq_ff        <= 1'b0;
      cmd_ready_ff  <= 1'b1;
      cmd_done_ff   <= 1'b0;
      resp_valid_ff <= 1'b0;
      resp_data_ff  <= 8'h00;
      poll_valid_ff <= 1'b0;
      poll_byte_ff  <= 8'h00;
      bus_trig_ff   <= 1'b0;
      init_ff       <= 1'b0;
      init_cont_ff  <= 1'b0;
      rom_start_ff  <= 1'b0;
      init_pend_ff  <= 1'b0;
      trig_pend_ff  <= 1'b0;
      settle_ff     <= 4'h0;
    end else begin
      state_ff      <= nxt_state;
      sre_ff        <= nxt_sre;
      stb_ff        <= byte_now;
      srq_ff        <= master_summary;
      cmd_ready_ff  <= nxt_cmd_ready;
      cmd_done_ff   <= nxt_cmd_done;
      resp_valid_ff <= nxt_resp_valid;
      resp_data_ff  <= nxt_resp_data;
      poll_valid_ff <= serial_poll_i;
      poll_byte_ff  <= serial_poll_i ? byte_now : poll_byte_ff;
      bus_trig_ff   <= nxt_bus_trig;
      init_ff       <= nxt_init;
      init_cont_ff  <= nxt_init_cont;
      rom_start_ff  <= nxt_rom_start;
      init_pend_ff  <= nxt_init_pend;
      trig_pend_ff  <= nxt_trig_pend;
      settle_ff     <= nxt_settle;
    end
  end

  // Outputs straight from flip-flops
  assign cmd_ready_o           = cmd_ready_ff;
  assign cmd_done_o            = cmd_done_ff;
  assign resp_valid_o          = resp_valid_ff;
  assign resp_data_o           = resp_data_ff;
  assign poll_valid_o          = poll_valid_ff;
  assign poll_byte_o           = poll_byte_ff;
  assign srq_o                 = srq_ff;
  assign bus_trigger_o         = bus_trig_ff;
  assign initiate_o            = init_ff;
  assign init_cont_on_o        = init_cont_ff;
  assign rom_check_start_o     = rom_start_ff;
  assign status_summary_byte_o = stb_ff;

endmodule // status_byte_and_sync_cmds

`default_nettype wire

/* verilog/status_sync_consts.vh */
// Constants for the status summary byte and command synchronisation block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef STATUS_SYNC_CONSTS_VH
`define STATUS_SYNC_CONSTS_VH

// ----------------------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------------------
`define SB_MEAS_BIT     3'd0
`define SB_UNUSED_BIT   3'd1
`define SB_ERRQ_BIT     3'd2
`define SB_QUES_BIT     3'd3
`define SB_OUTQ_BIT     3'd4
`define SB_STDEV_BIT    3'd5
`define SB_MSS_BIT      3'd6
`define SB_OPER_BIT     3'd7

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define SRE_RESET       8'h00
`define SRE_WRITE_MASK  8'hBD
`define STB_RESET       8'h00

// ----------------------------------------------------------------------------
// Command codes presented on the command port
// ----------------------------------------------------------------------------
`define CMD_NOP         4'h0
`define CMD_STB_QUERY   4'h1
`define CMD_SRE_WRITE   4'h2
`define CMD_SRE_QUERY   4'h3
`define CMD_TRIGGER     4'h4
`define CMD_SELFTEST    4'h5
`define CMD_WAIT        4'h6
`define CMD_INIT        4'h7
`define CMD_INIT_CONT   4'h8
`define CMD_OTHER       4'h9

// ----------------------------------------------------------------------------
// Self-test result codes
// ----------------------------------------------------------------------------
`define TST_PASS        8'h00
`define TST_FAIL        8'h01

// ----------------------------------------------------------------------------
// Sequencer timing
// ----------------------------------------------------------------------------
`define TRIG_SETTLE_CYC 4'h2

`endif

/* sim/status_sync_asserts.sv */
// Checker for the status byte and command sync block, bound to its top ports.
// Assumes the constants header is on the include path and one clock domain.
`include "status_sync_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module status_sync_asserts (
  // Clock, reset and command port
  input wire logic       clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, cmd_done_o, resp_valid_o,
  input wire logic [3:0] cmd_code_i,
  input wire logic [7:0] resp_data_o, status_summary_byte_o,
  // Triggers, poll, model, checksum and summary sources
  input wire logic       bus_get_i, trig_src_bus_i, bus_trigger_o, serial_poll_i, poll_valid_o,
  input wire logic       initiate_o, model_idle_i, rom_check_done_i, rom_check_ok_i,
  input wire logic       meas_event_i, err_queue_nonempty_i, ques_cal_err_i,
  input wire logic       out_queue_nonempty_i, std_event_enabled_i, oper_event_enabled_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic take = cmd_valid_i && cmd_ready_o;
  logic      wait_pend_ff;
  // Tracks an accepted wait until its completion pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) wait_pend_ff <= 1'b0;
    else if (take && cmd_code_i == `CMD_WAIT) wait_pend_ff <= 1'b1;
    else if (cmd_done_o) wait_pend_ff <= 1'b0;
  end
  AST_SRC_BITS: assert property ({status_summary_byte_o[7], status_summary_byte_o[5:2], status_summary_byte_o[0]} ==
    $past({oper_event_enabled_i, std_event_enabled_i, out_queue_nonempty_i, ques_cal_err_i,
    err_queue_nonempty_i, meas_event_i})) else $error("status byte does not follow its sources");
  AST_BIT1_ZERO: assert property (!status_summary_byte_o[1]) else $error("unused status bit set");
  AST_STB_ANSWER: assert property (take && cmd_code_i == `CMD_STB_QUERY |=>
    resp_valid_o && cmd_done_o && resp_data_o == status_summary_byte_o) else $error("bad status answer");
  AST_TRIG_GATE: assert property (bus_trigger_o |-> $past(trig_src_bus_i)) else $error("trigger not gated");
  AST_GET_TRIG: assert property (bus_get_i && trig_src_bus_i |=> bus_trigger_o) else $error("bus trigger lost");
  AST_POLL: assert property (serial_poll_i |=> poll_valid_o) else $error("poll not answered");
  AST_INIT: assert property (take && cmd_code_i == `CMD_INIT |=> initiate_o) else $error("initiate lost");
  AST_WAIT_HOLD: assert property (take && cmd_code_i == `CMD_WAIT |=> !cmd_ready_o) else $error("wait not held");
  AST_WAIT_IDLE: assert property (wait_pend_ff && cmd_done_o |-> $past(model_idle_i)) else $error("early release");
  AST_SELFTEST: assert property (rom_check_done_i |=> resp_valid_o &&
    resp_data_o == ($past(rom_check_ok_i) ? `TST_PASS : `TST_FAIL)) else $error("bad self-test code");
endmodule // status_sync_asserts
bind status_byte_and_sync_cmds status_sync_asserts u_asserts (.clk_i, .rst_n_i, .cmd_valid_i, .cmd_ready_o,
  .cmd_done_o, .resp_valid_o, .cmd_code_i, .resp_data_o, .status_summary_byte_o, .bus_get_i, .trig_src_bus_i,
  .bus_trigger_o, .serial_poll_i, .poll_valid_o, .initiate_o, .model_idle_i, .rom_check_done_i, .rom_check_ok_i,
  .meas_event_i, .err_queue_nonempty_i, .ques_cal_err_i, .out_queue_nonempty_i, .std_event_enabled_i,
  .oper_event_enabled_i);
`default_nettype wire

/* sim/far_side_model.sv */
// Behavioural trigger model and ROM checksum engine facing the block.
// Assumes single-cycle request pulses from the block on clk_i.
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(parameter int RUN_CYC = 12, parameter int MOVE_CYC = 6) (
  // Clock, reset and requests
  input wire logic clk_i, rst_n_i, start_run_i, trig_i, rom_start_i, rom_pass_i,
  // Model state and checksum answer
  output logic     model_idle_o, model_moving_o, rom_done_o, rom_ok_o
);
  int         run_ff, move_ff;
  logic [2:0] rom_ff;
  // Busy counters; a new request restarts the count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_ff <= 0;
      move_ff <= 0;
      rom_ff <= 3'h0;
    end else begin
      run_ff <= start_run_i ? RUN_CYC : (run_ff > 0 ? run_ff - 1 : 0);
      move_ff <= trig_i ? MOVE_CYC : (move_ff > 0 ? move_ff - 1 : 0);
      rom_ff <= {rom_ff[1:0], rom_start_i};
    end
  end
  assign model_idle_o = (run_ff == 0);
  assign model_moving_o = (move_ff != 0);
  assign rom_done_o = rom_ff[2];
  // Verdict line shows the inverse outside the done pulse, never a stale pass
  assign rom_ok_o = rom_done_o ? rom_pass_i : ~rom_pass_i;
endmodule // far_side_model
`default_nettype wire

/* sim/status_byte_and_sync_cmds_test.sv */
// Self-checking bench for the status byte and command sync block.
// Assumes the far-side model and the bound checker are compiled alongside.
`include "status_sync_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module status_byte_and_sync_cmds_test;
  logic       clk, rst_n, cmd_valid, cmd_ready, cmd_done, resp_valid, bus_get, poll, poll_valid, srq;
  logic       trig_src, idle, moving, bus_trig, init, init_cont, rom_start, rom_done, rom_ok, rom_pass;
  logic [3:0] cmd_code;
  logic [5:0] src;
  logic [7:0] cmd_data, resp_data, poll_byte, stb, r, n_trig, n0;
  int         n_mismatch, n_compared, c, k, quiet;
  status_byte_and_sync_cmds dut (.clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
    .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready), .cmd_done_o(cmd_done), .resp_valid_o(resp_valid),
    .resp_data_o(resp_data), .bus_get_i(bus_get), .serial_poll_i(poll), .poll_valid_o(poll_valid),
    .poll_byte_o(poll_byte), .srq_o(srq), .meas_event_i(src[0]), .err_queue_nonempty_i(src[1]),
    .ques_cal_err_i(src[2]), .out_queue_nonempty_i(src[3]), .std_event_enabled_i(src[4]),
    .oper_event_enabled_i(src[5]), .trig_src_bus_i(trig_src), .model_idle_i(idle), .model_moving_i(moving),
    .bus_trigger_o(bus_trig), .initiate_o(init), .init_cont_on_o(init_cont), .rom_check_start_o(rom_start),
    .rom_check_done_i(rom_done), .rom_check_ok_i(rom_ok), .status_summary_byte_o(stb));
  far_side_model partner (.clk_i(clk), .rst_n_i(rst_n), .start_run_i(init | init_cont), .trig_i(bus_trig),
    .rom_start_i(rom_start), .rom_pass_i(rom_pass), .model_idle_o(idle), .model_moving_o(moving),
    .rom_done_o(rom_done), .rom_ok_o(rom_ok));
  // Clock, trigger pulse count and settle time since the model stopped moving
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      n_trig <= 8'h00;
      quiet <= 0;
    end else begin
      n_trig <= n_trig + (bus_trig === 1'b1 ? 8'h01 : 8'h00);
      quiet <= moving ? 0 : quiet + 1;
    end
  end
  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Hold the request until ready is sampled, then count cycles up to done
  task automatic cmd(input logic [3:0] code, input logic [7:0] data);
    int i;
    cmd_code = code;
    cmd_data = data;
    cmd_valid = 1'b1;
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) step(1);
    step(1);
    cmd_valid = 1'b0;
    for (c = 0; c < 200 && cmd_done !== 1'b1; c++) step(1);
    r = resp_valid ? resp_data : 8'hxx;
    // Let an edge pass so the next request never re-raises valid at once
    step(1);
    if (i == 200 || c == 200) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // Scenarios: each source alone then all; mask and poll; triggers; waits; self-test
  task automatic t_sources();
    for (k = 0; k < 7; k++) begin
      src = (k == 6) ? 6'h3F : 6'h01 << k;
      step(2);
      chk("status byte", {src[5], 1'b0, src[4:1], 1'b0, src[0]}, stb);
      cmd(`CMD_STB_QUERY, 8'h00);
      chk("status query", {src[5], 1'b0, src[4:1], 1'b0, src[0]}, r);
      cmd(`CMD_STB_QUERY, 8'h00);
      chk("repeat query", {src[5], 1'b0, src[4:1], 1'b0, src[0]}, r);
    end
  endtask
  task automatic t_enable();
    cmd(`CMD_SRE_WRITE, 8'hFF);
    cmd(`CMD_SRE_QUERY, 8'h00);
    chk("enable mask", 8'hBD, r);
    src = 6'h02;
    step(3);
    chk("service request", 8'h01, {7'h00, srq});
    poll = 1'b1;
    step(1);
    poll = 1'b0;
    chk("poll byte", 8'h44, poll_valid ? poll_byte : 8'hxx);
    cmd(`CMD_SRE_WRITE, 8'h01);
    step(3);
    chk("masked byte", 8'h04, stb);
    src = 6'h00;
  endtask
  task automatic t_trigger();
    n0 = n_trig;
    cmd(`CMD_TRIGGER, 8'h00);
    bus_get = 1'b1;
    step(1);
    bus_get = 1'b0;
    step(3);
    chk("ignored triggers", n0, n_trig);
    trig_src = 1'b1;
    cmd(`CMD_TRIGGER, 8'h00);
    bus_get = 1'b1;
    step(1);
    bus_get = 1'b0;
    step(10);
    chk("accepted triggers", n0 + 8'h02, n_trig);
  endtask
  task automatic t_wait();
    cmd(`CMD_INIT, 8'h00);
    cmd(`CMD_WAIT, 8'h00);
    chk("idle at release", 8'h01, {7'h00, idle && c >= 10});
    cmd(`CMD_INIT_CONT, 8'h00);
    cmd(`CMD_WAIT, 8'h00);
    chk("idle after continuous", 8'h01, {7'h00, idle && c >= 10});
    cmd(`CMD_TRIGGER, 8'h00);
    cmd(`CMD_WAIT, 8'h00);
    chk("settled at release", 8'h01, {7'h00, quiet >= 2});
    cmd(`CMD_OTHER, 8'h00);
    chk("sequential latency", 8'h00, c[7:0]);
  endtask
  initial begin
    {rst_n, cmd_valid, cmd_code, cmd_data, bus_get, poll, src, trig_src} = '0;
    rom_pass = 1'b1;
    step(8);
    rst_n = 1'b1;
    step(1);
    cmd(`CMD_SRE_QUERY, 8'h00);
    chk("enable after reset", `SRE_RESET, r);
    t_sources();
    t_enable();
    t_trigger();
    t_wait();
    for (k = 0; k < 2; k++) begin
      rom_pass = (k == 0);
      cmd(`CMD_SELFTEST, 8'h00);
      chk("self-test code", (k == 0) ? `TST_PASS : `TST_FAIL, r);
    end
    end_of_test();
  end
endmodule // status_byte_and_sync_cmds_test
`default_nettype wire
